// ---- hdl/pls_pkg.sv ----
/*
 * Shared types and constants of the position limit and wrap supervisor:
 * register map, field positions, reset values and the signal bundles.
 * Assumes one 100 MHz APB clock domain and a 32-bit APB data path.
 */
package pls_pkg;

	localparam int POS_W   = 24;
	localparam int GEAR_W  = 16;
	localparam int ADDR_W  = 8;
	localparam int EV_W    = 8;
	localparam int MOD_W   = 48;

	////////////////////////////////////////////////////////////////////////
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_POS_LIM  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_NEG_LIM  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_WRAP     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_GEAR     = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_CMD_POS  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h24;

	// Control register fields
	localparam int CTRL_SWOT    = 0;
	localparam int CTRL_STOPACT = 1;
	localparam int CTRL_HOMEALM = 2;
	localparam int CTRL_WRAP    = 3;

	// Gear register fields
	localparam int GEAR_A_LSB = 0;
	localparam int GEAR_B_LSB = 16;

	// Command register fields (write-only pulses)
	localparam int CMD_CONFIG = 0;
	localparam int CMD_CLR    = 1;

	// Status register fields
	localparam int ST_ORIGIN   = 0;
	localparam int ST_HOME_ALM = 1;
	localparam int ST_ABS_ALM  = 2;
	localparam int ST_WWARN    = 3;
	localparam int ST_WALM     = 4;
	localparam int ST_SOFT_POS = 5;
	localparam int ST_SOFT_NEG = 6;
	localparam int ST_HW_POS   = 7;
	localparam int ST_HW_NEG   = 8;

	// Event bits, shared by interrupt status and mask
	localparam int EV_SOFT   = 0;
	localparam int EV_HW     = 1;
	localparam int EV_LIMCHG = 2;
	localparam int EV_HOME   = 3;
	localparam int EV_ABS    = 4;
	localparam int EV_WWARN  = 5;
	localparam int EV_WALM   = 6;
	localparam int EV_WRAP   = 7;

	////////////////////////////////////////////////////////////////////////
	// Reset values and arithmetic constants
	localparam logic [POS_W-1:0]  POS_LIM_RST = 24'h7fffff;
	localparam logic [POS_W-1:0]  NEG_LIM_RST = 24'h800000;
	localparam logic [POS_W-1:0]  WRAP_RST    = 24'h0003e8;
	localparam logic [GEAR_W-1:0] GEAR_RST    = 16'h0001;
	localparam logic [POS_W-1:0]  POS_ZERO    = 24'h000000;
	localparam logic [POS_W-1:0]  POS_ONE     = 24'h000001;
	localparam logic [MOD_W-1:0]  GEAR_B_MUL  = 48'h0000000003e8;
	localparam logic [MOD_W-1:0]  GEAR_A_MUL  = 48'h000000000032;

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		MV_POSITIONING = 2'h0,
		MV_CONTINUOUS  = 2'h1,
		MV_TEST        = 2'h2,
		MV_HOMING      = 2'h3
	} pls_move_t;

	// Gray sequence along the power-up path
	typedef enum logic [1:0] {
		PH_WAIT0 = 2'h0,
		PH_WAIT1 = 2'h1,
		PH_PWRUP = 2'h3,
		PH_RUN   = 2'h2
	} pls_phase_t;

	// Asynchronous pins, synchronised inside the block
	typedef struct packed {
		logic       ls_pos;
		logic       ls_neg;
		logic       preset;
		logic       abs_clr;
		logic       start;
		logic       seq_start;
		logic [5:0] direct_sel;
		logic       abs_err;
		logic       backup_en;
		logic       backup_kept;
	} pls_pins_t;

	// From the motion generator, same clock
	typedef struct packed {
		logic      step_valid;
		logic      step_dir;
		pls_move_t move_type;
		logic      moving;
		logic      home_done;
	} pls_motion_in_t;

	typedef struct packed {
		logic stop_immediate;
		logic stop_decel;
		logic allow_pos;
		logic allow_neg;
		logic start_grant;
		logic multiturn_clear;
	} pls_motion_out_t;

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		pls_phase_t        ph;
		logic              sw_ot_en;
		logic              stop_action;
		logic              home_alarm_en;
		logic              wrap_en;
		logic [POS_W-1:0]  pos_lim;
		logic [POS_W-1:0]  neg_lim;
		logic [POS_W-1:0]  wrap_range;
		logic [GEAR_W-1:0] gear_a;
		logic [GEAR_W-1:0] gear_b;
		logic [EV_W-1:0]   int_stat;
		logic [EV_W-1:0]   int_mask;
		logic [POS_W-1:0]  cmd_pos;
		logic              origin;
		logic              home_alarm;
		logic              abs_alarm;
		logic              wrap_warn;
		logic              wrap_alarm;
		pls_motion_out_t   mo;
		logic              irq;
		pls_pins_t         sync1;
		pls_pins_t         sync2;
		pls_pins_t         prev;
	} pls_state_t;

endpackage

// ---- hdl/pls_supervisor.sv ----
/*
 * Position limit and wrap supervisor: keeps the command position, checks
 * soft and hardware limits, owns the position origin, the home-incomplete
 * and absolute-position alarms and the wrap function, with an APB slave.
 * Assumes the motion generator runs on pclk and reports every step; all
 * pins are asynchronous and pass a two-stage synchroniser.
 */
// Register access over APB and the register addresses were chosen for this implementation.
module pls_supervisor
	import pls_pkg::*;
(
	input  logic                     pclk,
	input  logic                     presetn,
	input  logic                     psel,
	input  logic                     penable,
	input  logic                     pwrite,
	input  logic [pls_pkg::ADDR_W-1:0] paddr,
	input  logic [31:0]              pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  pls_pkg::pls_pins_t       pins,
	input  pls_pkg::pls_motion_in_t  motion_in,
	output pls_pkg::pls_motion_out_t motion_out,
	output logic [pls_pkg::POS_W-1:0] cmd_pos,
	output logic                     origin_set,
	output logic                     alarm_home,
	output logic                     alarm_abs,
	output logic                     warn_wrap,
	output logic                     alarm_wrap,
	output logic                     irq
);
	import pls_pkg::*;

	pls_state_t        s;
	pls_state_t        n;
	logic [EV_W-1:0]   ev;
	logic [31:0]       rdata;
	logic              rerr;
	logic              acc_wr;
	logic              acc_rd;
	logic              lim_wr;
	logic              cfg_cmd;
	logic              clr_cmd;
	logic              run;
	logic              pwr_up;
	logic              soft_act;
	logic              soft_pos;
	logic              soft_neg;
	logic              escape_ok;
	logic              allow_pos;
	logic              allow_neg;
	logic              violate;
	logic              stop;
	logic              abs_rise;
	logic              preset_rise;
	logic              start_rise;
	logic [POS_W:0]    stepped;
	logic [MOD_W-1:0]  mul_a;
	logic [MOD_W-1:0]  mul_b;
	logic [MOD_W-1:0]  mul_w;

	////////////////////////////////////////////////////////////////////////
	function automatic logic is_multiple(input logic [MOD_W-1:0] num,
		input logic [MOD_W-1:0] den);
		is_multiple = (den != '0) && ((num % den) == '0);
	endfunction

	// Rising edge of a synchronised pin against its last sample
	function automatic logic rise(input logic cur, input logic last);
		rise = cur && !last;
	endfunction

	// Signed test: has pos reached lim going up (up=1) or down (up=0)
	function automatic logic reached(input logic [POS_W-1:0] pos,
		input logic [POS_W-1:0] lim, input logic up);
		if (up) begin
			reached = $signed(pos) >= $signed(lim);
		end else begin
			reached = $signed(pos) <= $signed(lim);
		end
	endfunction

	// Returns {wrapped, next position}
	function automatic logic [POS_W:0] step_pos(input logic [POS_W-1:0] pos,
		input logic up, input logic wrap, input logic [POS_W-1:0] range);
		logic [POS_W-1:0] inc;
		logic [POS_W-1:0] dec;
		inc = pos + POS_ONE;
		dec = pos - POS_ONE;
		if (!wrap) begin
			step_pos = {1'b0, up ? inc : dec};
		end else if (up) begin
			// Out-of-range start (wrap just enabled) also folds to zero
			if ($signed(inc) >= $signed(range) || $signed(inc) < $signed(POS_ZERO)) begin
				step_pos = {1'b1, POS_ZERO};
			end else begin
				step_pos = {1'b0, inc};
			end
		end else begin
			// Going below zero lands on range-1, mirroring the upward fold
			if ($signed(pos) <= $signed(POS_ZERO) || $signed(pos) > $signed(range)) begin
				step_pos = {1'b1, range - POS_ONE};
			end else begin
				step_pos = {1'b0, dec};
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register read mux, captured in the first access cycle
	always_comb begin
		rdata = '0;
		rerr  = 1'b0;
		case (paddr)
			OFF_CTRL: begin
				rdata[CTRL_SWOT]    = s.sw_ot_en;
				rdata[CTRL_STOPACT] = s.stop_action;
				rdata[CTRL_HOMEALM] = s.home_alarm_en;
				rdata[CTRL_WRAP]    = s.wrap_en;
			end
			OFF_POS_LIM: rdata[POS_W-1:0] = s.pos_lim;
			OFF_NEG_LIM: rdata[POS_W-1:0] = s.neg_lim;
			OFF_WRAP:    rdata[POS_W-1:0] = s.wrap_range;
			OFF_GEAR: begin
				rdata[GEAR_A_LSB +: GEAR_W] = s.gear_a;
				rdata[GEAR_B_LSB +: GEAR_W] = s.gear_b;
			end
			OFF_STATUS: begin
				rdata[ST_ORIGIN]   = s.origin;
				rdata[ST_HOME_ALM] = s.home_alarm;
				rdata[ST_ABS_ALM]  = s.abs_alarm;
				rdata[ST_WWARN]    = s.wrap_warn;
				rdata[ST_WALM]     = s.wrap_alarm;
				rdata[ST_SOFT_POS] = soft_pos;
				rdata[ST_SOFT_NEG] = soft_neg;
				rdata[ST_HW_POS]   = s.sync2.ls_pos;
				rdata[ST_HW_NEG]   = s.sync2.ls_neg;
			end
			OFF_INT_STAT: rdata[EV_W-1:0]  = s.int_stat;
			OFF_INT_MASK: rdata[EV_W-1:0]  = s.int_mask;
			OFF_CMD_POS:  rdata[POS_W-1:0] = s.cmd_pos;
			// Command bits are pulses and read back as zero
			OFF_CMD:      rdata = '0;
			default:      rerr = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Limit supervision, from registered state and the live motion_in inputs
	always_comb begin
		run      = (s.ph == PH_RUN);
		soft_act = s.sw_ot_en && !s.wrap_en && s.origin;
		// Inclusive hit: standing on a limit already blocks further travel
		soft_pos = soft_act && reached(s.cmd_pos, s.pos_lim, 1'b1);
		soft_neg = soft_act && reached(s.cmd_pos, s.neg_lim, 1'b0);
		// Positioning moves stay locked while any sensor is active
		escape_ok = (motion_in.move_type != MV_POSITIONING);
		allow_pos = !soft_pos && !s.sync2.ls_pos && (escape_ok || !s.sync2.ls_neg);
		allow_neg = !soft_neg && !s.sync2.ls_neg && (escape_ok || !s.sync2.ls_pos);
		// Checked against the registered position, so a stop trails one step
		violate   = motion_in.moving && motion_in.step_valid
			&& (motion_in.step_dir ? !allow_pos : !allow_neg);
		mul_a = 48'(s.gear_a) * GEAR_A_MUL;
		mul_b = 48'(s.gear_b) * GEAR_B_MUL;
		mul_w = 48'(s.wrap_range) * mul_a;
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		n           = s;
		ev          = '0;
		lim_wr      = 1'b0;
		cfg_cmd     = 1'b0;
		clr_cmd     = 1'b0;
		pwr_up      = 1'b0;
		stepped     = '0;
		n.mo.stop_immediate  = 1'b0;
		n.mo.stop_decel      = 1'b0;
		n.mo.start_grant     = 1'b0;
		n.mo.multiturn_clear = 1'b0;

		// Only sync2 is read; sync1 feeds it alone
		n.sync1 = pins;
		n.sync2 = s.sync1;
		n.prev  = s.sync2;

		// APB: one wait state, answer registered
		acc_wr   = psel && penable && s.pready && pwrite;
		acc_rd   = psel && penable && s.pready && !pwrite;
		n.pready = psel && penable && !s.pready;
		if (psel && penable && !s.pready) begin
			n.prdata  = pwrite ? 32'h00000000 : rdata;
			n.pslverr = rerr;
		end else begin
			n.prdata  = '0;
			n.pslverr = 1'b0;
		end

		if (acc_wr) begin
			case (paddr)
				OFF_CTRL: begin
					n.sw_ot_en      = pwdata[CTRL_SWOT];
					n.stop_action   = pwdata[CTRL_STOPACT];
					n.home_alarm_en = pwdata[CTRL_HOMEALM];
					n.wrap_en       = pwdata[CTRL_WRAP];
				end
				// Rewriting the same value still counts as a change; no compare
				OFF_POS_LIM: begin
					n.pos_lim = pwdata[POS_W-1:0];
					lim_wr    = 1'b1;
				end
				OFF_NEG_LIM: begin
					n.neg_lim = pwdata[POS_W-1:0];
					lim_wr    = 1'b1;
				end
				OFF_WRAP: begin
					// Zero and negative ranges are ignored
					if (pwdata[POS_W-1:0] != POS_ZERO && !pwdata[POS_W-1]) begin
						n.wrap_range = pwdata[POS_W-1:0];
					end
				end
				OFF_GEAR: begin
					n.gear_a = pwdata[GEAR_A_LSB +: GEAR_W];
					n.gear_b = pwdata[GEAR_B_LSB +: GEAR_W];
				end
				OFF_INT_MASK: n.int_mask = pwdata[EV_W-1:0];
				OFF_CMD: begin
					cfg_cmd = pwdata[CMD_CONFIG];
					clr_cmd = pwdata[CMD_CLR];
				end
				// Read-only and unmapped offsets drop the write
				default: ;
			endcase
		end

		// Power-up sequence waits for the synchronisers to fill
		// Settings are at defaults here (wrap off), so escalation on power-up
		// only matters once settings survive a reset
		case (s.ph)
			PH_WAIT0: n.ph = PH_WAIT1;
			PH_WAIT1: n.ph = PH_PWRUP;
			PH_PWRUP: begin
				n.ph   = PH_RUN;
				pwr_up = 1'b1;
				n.origin = s.sync2.backup_en && s.sync2.backup_kept;
			end
			PH_RUN:   n.ph = PH_RUN;
			default:  n.ph = PH_RUN;
		endcase

		abs_rise    = run && rise(s.sync2.abs_err, s.prev.abs_err);
		preset_rise = run && rise(s.sync2.preset, s.prev.preset);
		start_rise  = run && (rise(s.sync2.start, s.prev.start)
			|| rise(s.sync2.seq_start, s.prev.seq_start)
			|| (|(s.sync2.direct_sel & ~s.prev.direct_sel)));

		// Overtravel and limit-change stops
		stop = violate || (lim_wr && motion_in.moving);
		n.mo.stop_immediate = stop && !s.stop_action;
		n.mo.stop_decel     = stop && s.stop_action;
		n.mo.allow_pos      = allow_pos;
		n.mo.allow_neg      = allow_neg;
		ev[EV_SOFT]   = violate && (soft_pos || soft_neg);
		ev[EV_HW]     = violate && (s.sync2.ls_pos || s.sync2.ls_neg);
		ev[EV_LIMCHG] = lim_wr && motion_in.moving;

		// Absolute position alarm; a new error wins over the clear pin
		if (abs_rise) begin
			n.abs_alarm = 1'b1;
			n.origin    = 1'b0;
			ev[EV_ABS]  = 1'b1;
		end else if (s.sync2.abs_clr) begin
			n.abs_alarm = 1'b0;
		end

		// Origin and command position
		// Steps keep counting during a stop; the motor may coast before halting
		if ((motion_in.home_done || preset_rise) && !s.abs_alarm && !abs_rise) begin
			n.origin  = 1'b1;
			n.cmd_pos = POS_ZERO;
		end else if (motion_in.step_valid) begin
			stepped   = step_pos(s.cmd_pos, motion_in.step_dir, s.wrap_en, s.wrap_range);
			n.cmd_pos = stepped[POS_W-1:0];
			n.mo.multiturn_clear = stepped[POS_W];
			ev[EV_WRAP] = stepped[POS_W];
		end

		// Start requests without an origin; a new alarm wins over the clear
		if (clr_cmd) begin
			n.home_alarm = 1'b0;
		end
		if (start_rise) begin
			if (s.home_alarm_en && !s.origin) begin
				n.home_alarm = 1'b1;
				ev[EV_HOME]  = 1'b1;
			end else if (!s.home_alarm) begin
				n.mo.start_grant = 1'b1;
			end
		end

		// Wrap integer conditions, checked only while wrap is on
		n.wrap_warn = s.wrap_en && !(is_multiple(mul_b, mul_a)
			&& is_multiple(mul_w, mul_b));
		ev[EV_WWARN] = n.wrap_warn && !s.wrap_warn;
		if (s.wrap_warn && (pwr_up || cfg_cmd)) begin
			n.wrap_alarm = 1'b1;
			ev[EV_WALM]  = !s.wrap_alarm;
		end else if (clr_cmd) begin
			n.wrap_alarm = 1'b0;
		end

		// Mask only gates the output; status bits collect regardless
		// Read clears only the bits that were reported; new events win
		n.int_stat = s.int_stat | ev;
		if (acc_rd && paddr == OFF_INT_STAT) begin
			n.int_stat = (s.int_stat & ~s.prdata[EV_W-1:0]) | ev;
		end
		n.irq = |(n.int_stat & n.int_mask);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s             <= '0;
			s.ph          <= PH_WAIT0;
			s.sw_ot_en    <= 1'b1;
			s.pos_lim     <= POS_LIM_RST;
			s.neg_lim     <= NEG_LIM_RST;
			s.wrap_range  <= WRAP_RST;
			s.gear_a      <= GEAR_RST;
			s.gear_b      <= GEAR_RST;
		end else begin
			s <= n;
		end
	end

	assign prdata     = s.prdata;
	assign pready     = s.pready;
	assign pslverr    = s.pslverr;
	assign motion_out = s.mo;
	assign cmd_pos    = s.cmd_pos;
	assign origin_set = s.origin;
	assign alarm_home = s.home_alarm;
	assign alarm_abs  = s.abs_alarm;
	assign warn_wrap  = s.wrap_warn;
	assign alarm_wrap = s.wrap_alarm;
	assign irq        = s.irq;

endmodule

// ---- dv/pls_supervisor_assertions.sv ----
/* Port-level checks of the position limit and wrap supervisor.
   Assumes one pclk domain and presetn as asynchronous active-low reset. */
module pls_supervisor_assertions (
	input logic                       pclk,
	input logic                       presetn,
	input logic                       psel,
	input logic                       penable,
	input logic                       pwrite,
	input logic [pls_pkg::ADDR_W-1:0] paddr,
	input logic [31:0]                pwdata,
	input logic                       pready,
	input logic                       pslverr,
	input pls_pkg::pls_motion_in_t    motion_in,
	input pls_pkg::pls_motion_out_t   motion_out,
	input logic [pls_pkg::POS_W-1:0]  cmd_pos,
	input logic                       origin_set,
	input logic                       alarm_home,
	input logic                       alarm_abs,
	input logic                       warn_wrap,
	input logic                       alarm_wrap
);
	timeunit 1ns;
	timeprecision 1ps;
	import pls_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	property p_pready_wait;
		psel && $rose(penable) |=> pready;
	endproperty
	a_pready_wait: assert property (p_pready_wait) else $error("no answer after one wait");
	property p_pready_only;
		pready |-> psel && penable && $past(penable);
	endproperty
	a_pready_only: assert property (p_pready_only) else $error("pready outside access");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	property p_stop_excl;
		!(motion_out.stop_immediate && motion_out.stop_decel);
	endproperty
	a_stop_excl: assert property (p_stop_excl) else $error("both stop kinds");
	property p_stop_moving;
		motion_out.stop_immediate || motion_out.stop_decel |-> $past(motion_in.moving);
	endproperty
	a_stop_moving: assert property (p_stop_moving) else $error("stop while idle");
	// Homing wins over a step in the same cycle unless the origin is locked out
	property p_home;
		motion_in.home_done && !alarm_abs |=> origin_set && cmd_pos == '0;
	endproperty
	a_home: assert property (p_home) else $error("homing left no origin");
	property p_abs;
		alarm_abs |=> !origin_set;
	endproperty
	a_abs: assert property (p_abs) else $error("origin kept under abs alarm");
	property p_grant;
		motion_out.start_grant |-> !alarm_home;
	endproperty
	a_grant: assert property (p_grant) else $error("grant under home alarm");
	property p_home_clr;
		$fell(alarm_home) |->
			$past(psel && penable && pready && pwrite && paddr == OFF_CMD && pwdata[CMD_CLR]);
	endproperty
	a_home_clr: assert property (p_home_clr) else $error("home alarm fell alone");
	property p_walarm;
		$rose(alarm_wrap) |-> $past(warn_wrap);
	endproperty
	a_walarm: assert property (p_walarm) else $error("wrap alarm without warning");
endmodule

bind pls_supervisor pls_supervisor_assertions pls_supervisor_assertions_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .motion_in(motion_in),
	.motion_out(motion_out), .cmd_pos(cmd_pos), .origin_set(origin_set),
	.alarm_home(alarm_home), .alarm_abs(alarm_abs), .warn_wrap(warn_wrap),
	.alarm_wrap(alarm_wrap));

// ---- dv/pls_motion_model.sv ----
/* Motion generator stand-in: a burst of steps on request.
   Assumes req is a one-cycle pulse and home is driven by the bench. */
module pls_motion_model (
	input  logic                     pclk,
	input  logic                     presetn,
	input  logic                     req,
	input  logic [15:0]              nstep,
	input  logic                     dir,
	input  pls_pkg::pls_move_t       mtype,
	input  logic                     home,
	input  pls_pkg::pls_motion_out_t motion_out,
	output pls_pkg::pls_motion_in_t  motion_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import pls_pkg::*;
	logic [15:0] left_reg;
	////////////////////////////////////////
	// A stopped burst is dropped, never resumed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			left_reg <= '0;
		else if (req)
			left_reg <= nstep;
		else if (motion_out.stop_immediate || motion_out.stop_decel)
			left_reg <= '0;
		else if (left_reg != '0)
			left_reg <= left_reg - 16'h1;
	end
	assign motion_in = '{step_valid: left_reg != '0, step_dir: dir, move_type: mtype,
		moving: left_reg != '0, home_done: home};
endmodule

// ---- dv/tb_top.sv ----
/* Directed bench of the supervisor: APB tasks, pins and step bursts.
   Assumes pls_motion_model in place of the motion generator. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pls_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic origin_set, alarm_home, alarm_abs, warn_wrap, alarm_wrap;
	logic req, dir, home, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] nstep;
	logic [POS_W-1:0] cmd_pos;
	pls_move_t mtype;
	pls_pins_t pins;
	pls_motion_in_t motion_in;
	pls_motion_out_t motion_out;
	int error_cnt, samples_checked, cyc, n_imm, n_dec, n_grant, n_mtc, k;

	pls_supervisor pls_supervisor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(pins), .motion_in(motion_in),
		.motion_out(motion_out), .cmd_pos(cmd_pos), .origin_set(origin_set),
		.alarm_home(alarm_home), .alarm_abs(alarm_abs), .warn_wrap(warn_wrap),
		.alarm_wrap(alarm_wrap), .irq(irq));
	pls_motion_model pls_motion_model_i (.pclk(pclk), .presetn(presetn), .req(req),
		.nstep(nstep), .dir(dir), .mtype(mtype), .home(home), .motion_out(motion_out),
		.motion_in(motion_in));
	////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (motion_out.stop_immediate === 1'b1)
			n_imm++;
		if (motion_out.stop_decel === 1'b1)
			n_dec++;
		if (motion_out.start_grant === 1'b1)
			n_grant++;
		if (motion_out.multiturn_clear === 1'b1)
			n_mtc++;
		if (cyc == 5000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// An extra edge after release keeps back-to-back calls off one time step
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic go(input logic d, input pls_move_t t, input int n);
		dir <= d;
		mtype <= t;
		nstep <= 16'(n);
		req <= 1'b1;
		@(posedge pclk);
		req <= 1'b0;
	endtask

	task automatic move(input logic d, input pls_move_t t, input int n);
		go(d, t, n);
		tick(n + 4);
	endtask

	task automatic preset_pin();
		pins.preset <= 1'b1;
		tick(6);
		pins.preset <= 1'b0;
		tick(6);
	endtask
	////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, req, dir, home} = '0;
		paddr = '0;
		pwdata = '0;
		pins = '0;
		nstep = '0;
		mtype = MV_POSITIONING;
		tick(3);
		presetn <= 1'b1;
		tick(4);
		rdc(OFF_CTRL, 32'h1);
		rdc(OFF_POS_LIM, 32'h7fffff);
		rdc(OFF_NEG_LIM, 32'h800000);
		rdc(OFF_WRAP, 32'h3e8);
		rdc(OFF_GEAR, 32'h10001);
		rdc(8'h40, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, OFF_CTRL, 32'h5);
		for (int i = 0; i < 3; i++) begin
			pins.start <= i == 0;
			pins.seq_start <= i == 1;
			pins.direct_sel <= {5'h0, i == 2};
			tick(6);
			chk(alarm_home, 1'b1);
			pins <= '0;
			apb(1'b1, OFF_CMD, 32'h2);
			chk(alarm_home, 1'b0);
		end
		apb(1'b1, OFF_CTRL, 32'h1);
		apb(1'b1, OFF_POS_LIM, 32'h5);
		rdc(OFF_INT_STAT, 32'h8);
		apb(1'b1, OFF_INT_MASK, 32'hff);
		move(1'b1, MV_POSITIONING, 8);
		chk(n_imm, 0);
		chk(cmd_pos, 24'h8);
		preset_pin();
		chk({origin_set, cmd_pos}, 25'h1000000);
		k = n_imm;
		move(1'b1, MV_POSITIONING, 8);
		chk(n_imm > k, 1'b1);
		chk(irq, 1'b1);
		chk({motion_out.allow_pos, motion_out.allow_neg}, 2'b01);
		apb(1'b0, OFF_INT_STAT, 32'h0);
		chk(rd, 32'h1);
		tick(2);
		chk(irq, 1'b0);
		k = n_imm + n_dec;
		move(1'b0, MV_POSITIONING, 2);
		chk(n_imm + n_dec, k);
		apb(1'b1, OFF_INT_MASK, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h3);
		k = n_dec;
		move(1'b1, MV_POSITIONING, 8);
		chk(n_dec > k, 1'b1);
		chk(irq, 1'b0);
		k = n_dec;
		go(1'b0, MV_POSITIONING, 40);
		apb(1'b1, OFF_POS_LIM, 32'h64);
		tick(40);
		chk(n_dec > k, 1'b1);
		pins.ls_pos <= 1'b1;
		tick(6);
		k = n_dec;
		move(1'b0, MV_POSITIONING, 3);
		chk(n_dec > k, 1'b1);
		k = n_dec;
		move(1'b0, MV_CONTINUOUS, 3);
		move(1'b0, MV_TEST, 3);
		move(1'b0, MV_HOMING, 3);
		chk(n_dec, k);
		pins.ls_pos <= 1'b0;
		apb(1'b1, OFF_POS_LIM, 32'h3);
		apb(1'b1, OFF_CTRL, 32'h9);
		apb(1'b1, OFF_WRAP, 32'h14);
		apb(1'b1, OFF_WRAP, 32'h0);
		rdc(OFF_WRAP, 32'h14);
		home <= 1'b1;
		@(posedge pclk);
		home <= 1'b0;
		tick(2);
		chk({origin_set, cmd_pos}, 25'h1000000);
		k = n_imm + n_dec;
		move(1'b1, MV_POSITIONING, 25);
		chk(cmd_pos, 24'h5);
		chk(n_imm + n_dec, k);
		move(1'b0, MV_POSITIONING, 7);
		chk(cmd_pos, 24'h12);
		chk(n_mtc, 2);
		rdc(OFF_CMD_POS, 32'h12);
		chk(warn_wrap, 1'b0);
		apb(1'b1, OFF_GEAR, 32'h10003);
		tick(2);
		chk(warn_wrap, 1'b1);
		apb(1'b1, OFF_GEAR, 32'h10001);
		tick(2);
		chk(warn_wrap, 1'b0);
		apb(1'b1, OFF_WRAP, 32'h1e);
		tick(2);
		chk(warn_wrap, 1'b1);
		apb(1'b1, OFF_CMD, 32'h1);
		tick(2);
		chk(alarm_wrap, 1'b1);
		pins.abs_err <= 1'b1;
		tick(6);
		pins.abs_err <= 1'b0;
		chk({alarm_abs, origin_set}, 2'b10);
		preset_pin();
		chk(origin_set, 1'b0);
		pins.abs_clr <= 1'b1;
		tick(6);
		pins.abs_clr <= 1'b0;
		preset_pin();
		chk({alarm_abs, origin_set}, 2'b01);
		rdc(OFF_STATUS, 32'h19);
		apb(1'b1, OFF_CTRL, 32'h5);
		pins.start <= 1'b1;
		tick(6);
		chk(n_grant, 1);
		chk(alarm_home, 1'b0);
		pins <= 15'h3;
		presetn <= 1'b0;
		tick(3);
		presetn <= 1'b1;
		tick(5);
		chk(origin_set, 1'b1);
		finish_test();
	end
endmodule
